//--- rtl/serial_ctrl_pkg.sv
// shared constants for the serial controller host port and baud generator
// assumes one 100 MHz system clock; the baud reference arrives as a pin
// How it works
// - small package: one low interrupt when any of status bits 0..2 is one
// - small package: change bit set only by carrier-detect; dset-ready bit ignored
// - small package: terminal-ready command bit kept readable but drives nothing
// - rate set a: divide 4.9152 MHz reference by 6144 down to 16
// - rate set b: divisors 6752 down to 8 on the 4.9152 MHz reference
// - rate set c: divide 5.0688 MHz reference by 6336 down to 16
// - async mode gives 16x clock; sync mode 1x and only the transmitter
// - high master reset clears mode, command, status; idle until reprogrammed
// - access done while chip enable low; data lines released while high
// - eight bit data bus, bit 0 least significant, two select inputs
// - transmit-ready output is inverse of status bit 0
// - receive-ready output is inverse of status bit 1, cleared by read
// - empty/change output low on tx empty or modem input change
// - status read clears change unless tx empty; then a load clears it
// - three host-written characters: first sync, second sync, link escape
// - two mode registers, command and status steer other sections
// - modem change flags only when command bit 2 or 0 is set
package serial_ctrl_pkg;
    localparam logic [1:0] SEL_DATA     = 2'h0;
    localparam logic [1:0] SEL_SYNC_DLE = 2'h1;
    localparam logic [1:0] SEL_MODE     = 2'h2;
    localparam logic [1:0] SEL_CMD      = 2'h3;
    localparam int         BIT_TX_RDY   = 0;
    localparam int         BIT_RX_RDY   = 1;
    localparam int         BIT_EMPTY    = 2;
    localparam int         BIT_DCD      = 6;
    localparam int         BIT_DSR      = 7;
    localparam int         CMD_TXEN     = 0;
    localparam int         CMD_TERM     = 1;
    localparam int         CMD_RXEN     = 2;
    localparam int         MODE_SYNC_LO = 0;
    localparam int         MODE_SYNC_HI = 1;
    localparam logic [7:0] ZERO8        = 8'h00;
    localparam logic [1:0] SET_A        = 2'h0;
    localparam logic [1:0] SET_B        = 2'h1;
    localparam logic [1:0] SET_C        = 2'h2;
    localparam int         DIV_W        = 13;
    typedef logic [DIV_W-1:0] div_t;
    typedef enum logic [1:0] {SEQ_M1 = 2'h0, SEQ_M2 = 2'h1, SEQ_S1 = 2'h3, SEQ_S2 = 2'h2} seq_t;
    // divisor tables, one per rate set, indexed by rate code
    function automatic div_t divisor(input logic [1:0] set, input logic [3:0] code);
        div_t a [16];
        div_t b [16];
        div_t c [16];
        a = '{13'h1800, 13'h1000, 13'h0ae9, 13'h08ec, 13'h0800, 13'h0600, 13'h0400, 13'h0200,
              13'h0124, 13'h0100, 13'h00ab, 13'h009a, 13'h0080, 13'h0040, 13'h0020, 13'h0010};
        b = '{13'h1a60, 13'h1800, 13'h1000, 13'h0ae9, 13'h08ec, 13'h0800, 13'h0400, 13'h0200,
              13'h0100, 13'h00ab, 13'h009a, 13'h0080, 13'h0040, 13'h0020, 13'h0010, 13'h0008};
        c = '{13'h18c0, 13'h1080, 13'h0b40, 13'h0933, 13'h0840, 13'h0420, 13'h0210, 13'h0108,
              13'h00b0, 13'h009e, 13'h0084, 13'h0058, 13'h0042, 13'h002c, 13'h0021, 13'h0010};
        case (set)
            SET_B:   return b[code];
            SET_C:   return c[code];
            default: return a[code];
        endcase
    endfunction : divisor
endpackage : serial_ctrl_pkg

//--- rtl/serial_ctrl_host_port.sv
// host port, status outputs and baud generator of the serial controller
// assumes host pins and reference clock are asynchronous; tx/rx engines sit outside
`timescale 1ns/10ps
module serial_ctrl_host_port
    import serial_ctrl_pkg::*;
#(
    parameter logic [1:0] RATE_SET  = SET_A,
    parameter bit         SMALL_PKG = 1'b0
)(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       master_reset,
    input  wire logic [1:0] reg_select,
    input  wire logic       rd_wr_n_sel,
    input  wire logic       chip_en_n,
    input  wire logic [7:0] host_data_in,
    output logic      [7:0] host_data_out,
    output logic            host_data_oe,
    input  wire logic       baud_ref_clk,
    input  wire logic       dset_ready_n,
    input  wire logic       carrier_n,
    input  wire logic       tx_load_ready,
    input  wire logic       tx_empty,
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_data,
    output logic            rx_ready,
    output logic            tx_valid,
    output logic      [7:0] tx_data,
    input  wire logic       tx_take,
    output logic      [7:0] mode1_q,
    output logic      [7:0] mode2_q,
    output logic      [7:0] cmd_q,
    output logic      [7:0] sync_char_first,
    output logic      [7:0] sync_char_second,
    output logic      [7:0] link_escape_char,
    output logic            tx_baud_tick,
    output logic            rx_baud_tick,
    output logic            tx_hold_ready_n,
    output logic            rx_hold_ready_n,
    output logic            tx_empty_or_dset_change_n,
    output logic            irq_n_combined,
    output logic            term_ready_n
);
    // ==========================================================
    // reset and pin synchronisers
    logic        rst_any_n;
    logic [14:0] s1_q;
    logic [14:0] s2_q;
    logic        ce_d1_q;
    logic        ref_d1_q;
    logic        dsr_d1_q;
    logic        dcd_d1_q;
    assign rst_any_n = rst_n & ~master_reset;
    always_ff @(posedge clock or negedge rst_any_n)
        if (!rst_any_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
        end
        else
        begin
            s1_q <= {~chip_en_n, rd_wr_n_sel, baud_ref_clk, dset_ready_n, carrier_n, reg_select, host_data_in};
            s2_q <= s1_q;
        end
    // select and data ride the same two flops as the enable, so all agree at the access pulse
    wire       ce_s  = s2_q[14];
    wire       wr_s  = s2_q[13];
    wire       ref_s = s2_q[12];
    wire       dsr_s = s2_q[11];
    wire       dcd_s = s2_q[10];
    wire [1:0] sel_s = s2_q[9:8];
    wire [7:0] din_s = s2_q[7:0];
    always_ff @(posedge clock or negedge rst_any_n)
        if (!rst_any_n)
        begin
            ce_d1_q  <= 1'b0;
            ref_d1_q <= 1'b0;
            dsr_d1_q <= 1'b0;
            dcd_d1_q <= 1'b0;
        end
        else
        begin
            ce_d1_q  <= ce_s;
            ref_d1_q <= ref_s;
            dsr_d1_q <= dsr_s;
            dcd_d1_q <= dcd_s;
        end
    wire access = ce_s & ~ce_d1_q;
    wire do_wr  = access & wr_s;
    wire do_rd  = access & ~wr_s;
    // ==========================================================
    // control registers
    seq_t seq_q;
    logic sel_dle_q;
    wire  sync_mode = mode1_q[MODE_SYNC_HI:MODE_SYNC_LO] == 2'h0;
    always_ff @(posedge clock or negedge rst_any_n)
        if (!rst_any_n)
        begin
            mode1_q          <= ZERO8;
            mode2_q          <= ZERO8;
            cmd_q            <= ZERO8;
            seq_q            <= SEQ_M1;
            sel_dle_q        <= 1'b0;
            sync_char_first  <= ZERO8;
            sync_char_second <= ZERO8;
            link_escape_char <= ZERO8;
        end
        else if (do_wr)
        begin
            case (sel_s)
                SEL_MODE:
                    case (seq_q)
                        SEQ_M1:
                        begin
                            mode1_q <= din_s;
                            seq_q   <= SEQ_M2;
                        end
                        default:
                        begin
                            mode2_q <= din_s;
                            seq_q   <= SEQ_M1;
                        end
                    endcase
                SEL_SYNC_DLE:
                    case (seq_q)
                        SEQ_S1:
                        begin
                            sync_char_second <= din_s;
                            seq_q            <= SEQ_S2;
                        end
                        SEQ_S2:
                        begin
                            link_escape_char <= din_s;
                            seq_q            <= SEQ_M1;
                        end
                        default:
                        begin
                            sync_char_first <= din_s;
                            seq_q           <= SEQ_S1;
                        end
                    endcase
                SEL_CMD:
                begin
                    cmd_q <= din_s;
                    seq_q <= SEQ_M1;
                end
                default: ;
            endcase
        end
        else if (do_rd && sel_s == SEL_CMD)
            seq_q <= SEQ_M1;
    assign term_ready_n = SMALL_PKG ? 1'b1 : ~cmd_q[CMD_TERM];
    // ==========================================================
    // two-entry buffers for the data paths
    logic [7:0] txb_q [2];
    logic [1:0] txn_q;
    logic [7:0] rxb_q [2];
    logic [1:0] rxn_q;
    wire tx_push = do_wr && sel_s == SEL_DATA && txn_q != 2'h2;
    wire rx_pop  = do_rd && sel_s == SEL_DATA && rxn_q != 2'h0;
    wire tx_pop  = tx_take && txn_q != 2'h0;
    assign tx_valid = txn_q != 2'h0;
    assign tx_data  = txb_q[0];
    assign rx_ready = rxn_q != 2'h2 && cmd_q[CMD_RXEN];
    wire rx_push = rx_valid && rx_ready;
    always_ff @(posedge clock or negedge rst_any_n)
        if (!rst_any_n)
        begin
            txb_q <= '{ZERO8, ZERO8};
            txn_q <= 2'h0;
            rxb_q <= '{ZERO8, ZERO8};
            rxn_q <= 2'h0;
        end
        else
        begin
            if (tx_pop)
                txb_q[0] <= txb_q[1];
            if (tx_push)
                txb_q[(txn_q - (tx_pop ? 2'h1 : 2'h0)) == 2'h0 ? 0 : 1] <= din_s;
            txn_q <= txn_q + (tx_push ? 2'h1 : 2'h0) - (tx_pop ? 2'h1 : 2'h0);
            if (!cmd_q[CMD_RXEN])
                rxn_q <= 2'h0;
            else
            begin
                if (rx_pop)
                    rxb_q[0] <= rxb_q[1];
                if (rx_push)
                    rxb_q[(rxn_q - (rx_pop ? 2'h1 : 2'h0)) == 2'h0 ? 0 : 1] <= rx_data;
                rxn_q <= rxn_q + (rx_push ? 2'h1 : 2'h0) - (rx_pop ? 2'h1 : 2'h0);
            end
        end
    // ==========================================================
    // status register
    logic change_q;
    logic empty_seen_q;
    logic [7:0] status;
    wire dsr_edge  = ~SMALL_PKG && (dsr_s ^ dsr_d1_q);
    wire dcd_edge  = dcd_s ^ dcd_d1_q;
    wire mdm_event = (dsr_edge | dcd_edge) & (cmd_q[CMD_RXEN] | cmd_q[CMD_TXEN]);
    wire stat_rd   = do_rd && sel_s == SEL_SYNC_DLE;
    always_ff @(posedge clock or negedge rst_any_n)
        if (!rst_any_n)
        begin
            change_q     <= 1'b0;
            empty_seen_q <= 1'b0;
        end
        else
        begin
            change_q <= mdm_event | (change_q & ~stat_rd);
            if (tx_push)
                empty_seen_q <= 1'b0;
            else if (tx_empty && txn_q == 2'h0 && cmd_q[CMD_TXEN])
                empty_seen_q <= 1'b1;
        end
    wire stat_tx_ready_bit     = cmd_q[CMD_TXEN] & tx_load_ready & (txn_q != 2'h2);
    wire stat_rx_ready_bit     = rxn_q != 2'h0;
    wire stat_empty_change_bit = change_q | empty_seen_q;
    wire stat_dset_ready_bit   = SMALL_PKG ? 1'b0 : ~dsr_s;
    assign status = {stat_dset_ready_bit, ~dcd_s, 3'h0, stat_empty_change_bit, stat_rx_ready_bit,
                     stat_tx_ready_bit};
    // ==========================================================
    // read data and pin outputs
    logic [7:0] rd_mux;
    always_comb
    begin
        case (sel_s)
            SEL_DATA:     rd_mux = rxb_q[0];
            SEL_SYNC_DLE: rd_mux = status;
            SEL_MODE:     rd_mux = seq_q == SEQ_M1 ? mode1_q : mode2_q;
            default:      rd_mux = cmd_q;
        endcase
    end
    always_ff @(posedge clock or negedge rst_any_n)
        if (!rst_any_n)
        begin
            host_data_out <= ZERO8;
            host_data_oe  <= 1'b0;
        end
        else
        begin
            if (do_rd)
                host_data_out <= rd_mux;
            host_data_oe <= ce_s & ~wr_s;
        end
    // open-drain pins: low means the pin is pulled down
    wire any_irq = stat_tx_ready_bit | stat_rx_ready_bit | stat_empty_change_bit;
    assign tx_hold_ready_n           = SMALL_PKG | ~stat_tx_ready_bit;
    assign rx_hold_ready_n           = SMALL_PKG | ~stat_rx_ready_bit;
    assign tx_empty_or_dset_change_n = SMALL_PKG | ~stat_empty_change_bit;
    assign irq_n_combined            = ~(SMALL_PKG & any_irq);
    // ==========================================================
    // baud generator on the reference clock edges
    div_t cnt_q;
    logic [3:0] sub_q;
    wire  ref_rise = ref_s & ~ref_d1_q;
    div_t div_val;
    assign div_val = divisor(RATE_SET, mode2_q[3:0]);
    logic tick16_q;
    logic tick1_q;
    always_ff @(posedge clock or negedge rst_any_n)
        if (!rst_any_n)
        begin
            cnt_q    <= '0;
            sub_q    <= 4'h0;
            tick16_q <= 1'b0;
            tick1_q  <= 1'b0;
        end
        else
        begin
            tick16_q <= 1'b0;
            tick1_q  <= 1'b0;
            if (ref_rise)
            begin
                if (cnt_q >= div_val - div_t'(1))
                begin
                    cnt_q    <= '0;
                    tick16_q <= 1'b1;
                    sub_q    <= sub_q + 4'h1;
                    tick1_q  <= sub_q == 4'hf;
                end
                else
                    cnt_q <= cnt_q + div_t'(1);
            end
        end
    // sync: 1x from the divided rate and transmitter only
    assign tx_baud_tick = sync_mode ? tick1_q : tick16_q;
    assign rx_baud_tick = sync_mode ? 1'b0 : tick16_q;
    // ==========================================================
    // checks
    a_irq_wired_or:  assert property (@(posedge clock) disable iff (!rst_any_n)
        SMALL_PKG |-> (irq_n_combined == ~|status[BIT_EMPTY:BIT_TX_RDY])) else $error("irq mismatch");
    a_rdy_inverse:   assert property (@(posedge clock) disable iff (!rst_any_n)
        !SMALL_PKG |-> tx_hold_ready_n == ~status[BIT_TX_RDY]) else $error("tx ready mismatch");
    a_rx_inverse:    assert property (@(posedge clock) disable iff (!rst_any_n)
        !SMALL_PKG |-> rx_hold_ready_n == ~status[BIT_RX_RDY]) else $error("rx ready mismatch");
    a_rx_disable:    assert property (@(posedge clock) disable iff (!rst_any_n)
        !cmd_q[CMD_RXEN] |=> !stat_rx_ready_bit) else $error("rx ready while disabled");
    a_change_gate:   assert property (@(posedge clock) disable iff (!rst_any_n)
        (!change_q && !(cmd_q[CMD_RXEN] | cmd_q[CMD_TXEN])) |=> !change_q) else $error("ungated change");
    a_stat_rd_clr:   assert property (@(posedge clock) disable iff (!rst_any_n)
        (stat_rd && !mdm_event) |=> !change_q) else $error("change not cleared");
    a_load_clr:      assert property (@(posedge clock) disable iff (!rst_any_n)
        tx_push |=> !empty_seen_q) else $error("empty not cleared on load");
    a_term_small:    assert property (@(posedge clock) disable iff (!rst_any_n)
        SMALL_PKG |-> term_ready_n) else $error("terminal ready driven");
    a_oe_ce:         assert property (@(posedge clock) disable iff (!rst_any_n)
        !ce_s |=> !host_data_oe) else $error("bus driven without enable");
    a_rx_tick_sync:  assert property (@(posedge clock) disable iff (!rst_any_n)
        sync_mode |-> !rx_baud_tick) else $error("rx tick in sync mode");
    a_empty_set:     assert property (@(posedge clock) disable iff (!rst_any_n)
        (tx_empty && txn_q == 2'h0 && cmd_q[CMD_TXEN] && !tx_push) |=> empty_seen_q) else $error("no empty flag");
    a_change_set:    assert property (@(posedge clock) disable iff (!rst_any_n)
        mdm_event |=> change_q) else $error("change lost");
    a_rx_pop_clr:    assert property (@(posedge clock) disable iff (!rst_any_n)
        (rx_pop && rxn_q == 2'h1 && !rx_push) |=> !stat_rx_ready_bit) else $error("rx ready after last read");
    a_small_dsr:     assert property (@(posedge clock) disable iff (!rst_any_n)
        SMALL_PKG |-> !status[BIT_DSR]) else $error("dset ready shown");
    c_tx_load:   cover property (@(posedge clock) disable iff (!rst_any_n) tx_push ##[1:20] tx_pop);
    c_rx_read:   cover property (@(posedge clock) disable iff (!rst_any_n) rx_push ##[1:50] rx_pop);
    c_baud_tick: cover property (@(posedge clock) disable iff (!rst_any_n) tick16_q);
    c_change:    cover property (@(posedge clock) disable iff (!rst_any_n) mdm_event ##[1:50] stat_rd);
    c_sync_tick: cover property (@(posedge clock) disable iff (!rst_any_n) sync_mode && tx_baud_tick);
endmodule : serial_ctrl_host_port

//--- verification/host_bus_model.sv
// host side model: resolves the shared data bus and the pulled-up interrupt pin
// assumes the bench drives host_en and host_val only while it writes
`timescale 1ns/10ps
module host_bus_model
(
    input  wire logic       clock,
    input  wire logic       host_en,
    input  wire logic [7:0] host_val,
    input  wire logic [7:0] dev_val,
    input  wire logic       dev_oe,
    input  wire logic       irq_en_n,
    output logic      [7:0] bus,
    output logic            irq_pin
);
    logic [7:0] last_q = 8'h00;

    // =========================================================
    // data bus
    always_ff @(posedge clock)
    begin
        last_q <= bus;
    end

    // a released bus toggles every cycle so stale data never matches
    always_comb
    begin
        if (dev_oe)
            bus = dev_val;
        else if (host_en)
            bus = host_val;
        else
            bus = ~last_q;
    end

    // =========================================================
    // pull-up on the open-drain interrupt line
    assign irq_pin = (irq_en_n === 1'b0) ? 1'b0 : 1'b1;
endmodule : host_bus_model

//--- verification/serial_ctrl_host_port_test.sv
// self-checking bench for the host port, small and full package, rate set b
// assumes the host bus model resolves the data bus and the interrupt pull-up
`timescale 1ns/10ps
module serial_ctrl_host_port_test
    import serial_ctrl_pkg::*;
;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic       master_reset = 1'b0;
    logic [1:0] reg_select = 2'h0;
    logic       rd_wr_n_sel = 1'b0;
    logic       chip_en_n = 1'b1;
    logic       host_en = 1'b0;
    logic [7:0] host_val = 8'h00;
    logic [1:0] ref_cnt = 2'h0;
    logic       baud_ref_clk = 1'b0;
    logic       dset_ready_n = 1'b1;
    logic       carrier_n = 1'b0;
    logic       tx_empty = 1'b0;
    logic       rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic       tx_take = 1'b0;
    logic [7:0] bus, host_data_out, mode1_q, mode2_q, cmd_q, sync_first, sync_second, esc_char, tx_data;
    logic       host_data_oe, rx_ready, tx_valid, tx_tick, rx_tick, irq_n, irq_pin, term_ready_n;
    wire  [2:0] pins_s;
    wire  [2:0] pins_f;
    wire        term_f;
    int         miscompares = 0;
    int         comparisons = 0;

    // =========================================================
    // clock, baud reference and parts
    always #5 clock = ~clock;

    always @(posedge clock)
    begin
        ref_cnt      <= ref_cnt + 2'h1;
        baud_ref_clk <= ref_cnt[1];
    end

    serial_ctrl_host_port #(.RATE_SET(SET_B), .SMALL_PKG(1'b1)) dut (
        .clock(clock), .rst_n(rst_n), .master_reset(master_reset), .reg_select(reg_select),
        .rd_wr_n_sel(rd_wr_n_sel), .chip_en_n(chip_en_n), .host_data_in(bus), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .baud_ref_clk(baud_ref_clk), .dset_ready_n(dset_ready_n),
        .carrier_n(carrier_n), .tx_load_ready(1'b1), .tx_empty(tx_empty), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_take(tx_take), .mode1_q(mode1_q),
        .mode2_q(mode2_q), .cmd_q(cmd_q), .sync_char_first(sync_first), .sync_char_second(sync_second),
        .link_escape_char(esc_char), .tx_baud_tick(tx_tick), .rx_baud_tick(rx_tick), .tx_hold_ready_n(pins_s[0]),
        .rx_hold_ready_n(pins_s[1]), .tx_empty_or_dset_change_n(pins_s[2]), .irq_n_combined(irq_n),
        .term_ready_n(term_ready_n));

    host_bus_model host (.clock(clock), .host_en(host_en), .host_val(host_val), .dev_val(host_data_out),
        .dev_oe(host_data_oe), .irq_en_n(irq_n), .bus(bus), .irq_pin(irq_pin));

    // same stimulus into a full-package copy, to see the three separate pins
    serial_ctrl_host_port #(.RATE_SET(SET_B), .SMALL_PKG(1'b0)) dut_full (
        .clock(clock), .rst_n(rst_n), .master_reset(master_reset), .reg_select(reg_select),
        .rd_wr_n_sel(rd_wr_n_sel), .chip_en_n(chip_en_n), .host_data_in(bus), .host_data_out(), .host_data_oe(),
        .baud_ref_clk(baud_ref_clk), .dset_ready_n(dset_ready_n), .carrier_n(carrier_n), .tx_load_ready(1'b1),
        .tx_empty(tx_empty), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(), .tx_valid(), .tx_data(),
        .tx_take(tx_take), .mode1_q(), .mode2_q(), .cmd_q(), .sync_char_first(), .sync_char_second(),
        .link_escape_char(), .tx_baud_tick(), .rx_baud_tick(), .tx_hold_ready_n(pins_f[0]),
        .rx_hold_ready_n(pins_f[1]), .tx_empty_or_dset_change_n(pins_f[2]), .irq_n_combined(),
        .term_ready_n(term_f));

    // =========================================================
    // tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic access(input logic [1:0] sel, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clock);
        reg_select  <= sel;
        rd_wr_n_sel <= wr;
        host_val    <= wd;
        host_en     <= wr;
        chip_en_n   <= 1'b0;
        repeat (5) @(posedge clock);
        #1;
        rd = bus;
        check(16'(host_data_oe), 16'(!wr), "oe during access");
        @(posedge clock);
        chip_en_n <= 1'b1;
        host_en   <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        check(16'(host_data_oe), 16'h0000, "oe after access");
    endtask : access

    task automatic put(input logic [1:0] sel, input logic [7:0] wd);
        logic [7:0] unused;
        access(sel, 1'b1, wd, unused);
    endtask : put

    task automatic get(input logic [1:0] sel, input logic [7:0] exp, input logic [7:0] mask, input string what);
        logic [7:0] rd;
        access(sel, 1'b0, 8'h00, rd);
        check(16'(rd & mask), 16'(exp), what);
    endtask : get

    task automatic wait_tick(output int n);
        n = 0;
        do
        begin
            @(posedge clock);
            #1;
            n++;
        end
        while (tx_tick !== 1'b1 && n < 40000);
    endtask : wait_tick

    task automatic tick_gap(input int exp);
        int n;
        wait_tick(n);
        wait_tick(n);
        check(16'(n), 16'(exp), "baud tick gap");
    endtask : tick_gap

    task automatic push(input logic [7:0] d, input logic exp, input string what);
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_data  <= d;
        #1;
        check(16'(rx_ready), 16'(exp), what);
        @(posedge clock);
        rx_valid <= 1'b0;
    endtask : push

    task automatic pop;
        @(posedge clock);
        tx_take <= 1'b1;
        @(posedge clock);
        tx_take <= 1'b0;
        #1;
    endtask : pop

    task automatic modem(input logic dcd, input logic dsr);
        @(posedge clock);
        carrier_n    <= dcd;
        dset_ready_n <= dsr;
        repeat (6) @(posedge clock);
        #1;
    endtask : modem

    task automatic print_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // =========================================================
    // tests
    initial
    begin
        logic rx_seen;
        logic tx_seen;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check({cmd_q, mode1_q}, 16'h0000, "regs after reset");
        check(16'(irq_pin), 16'h0001, "irq released");
        check({5'h00, pins_s, 5'h00, pins_f}, 16'h0707, "pins released");
        put(SEL_CMD, 8'h07);
        get(SEL_CMD, 8'h07, 8'hff, "cmd readback");
        check({7'h00, term_ready_n, 7'h00, term_f}, 16'h0100, "term ready");
        put(SEL_MODE, 8'h02);
        put(SEL_MODE, 8'h0f);
        check({mode1_q, mode2_q}, 16'h020f, "mode regs");
        get(SEL_MODE, 8'h02, 8'hff, "mode readback");
        put(SEL_CMD, 8'h07);
        put(SEL_SYNC_DLE, 8'h16);
        put(SEL_SYNC_DLE, 8'h17);
        put(SEL_SYNC_DLE, 8'h10);
        check({sync_first, sync_second}, 16'h1617, "sync chars");
        check(16'(esc_char), 16'h0010, "escape char");
        tick_gap(32);
        put(SEL_CMD, 8'h07);
        put(SEL_MODE, 8'h02);
        put(SEL_MODE, 8'h00);
        tick_gap(27008);
        put(SEL_CMD, 8'h07);
        put(SEL_MODE, 8'h00);
        put(SEL_MODE, 8'h0f);
        rx_seen = 1'b0;
        tx_seen = 1'b0;
        repeat (1100)
        begin
            @(posedge clock);
            #1;
            rx_seen = rx_seen | rx_tick;
            tx_seen = tx_seen | tx_tick;
        end
        check({7'h00, tx_seen, 7'h00, rx_seen}, 16'h0100, "sync mode ticks");
        put(SEL_DATA, 8'ha5);
        put(SEL_DATA, 8'h5a);
        put(SEL_DATA, 8'hc3);
        check({7'h00, tx_valid, tx_data}, 16'h01a5, "tx head");
        get(SEL_SYNC_DLE, 8'h00, 8'h01, "tx ready when full");
        pop;
        check(16'(tx_data), 16'h005a, "tx second");
        pop;
        check(16'(tx_valid), 16'h0000, "third write refused");
        get(SEL_SYNC_DLE, 8'h01, 8'h01, "tx ready when empty");
        check({5'h00, pins_s, 5'h00, pins_f}, 16'h0706, "pins tx ready");
        @(posedge clock);
        tx_empty <= 1'b1;
        get(SEL_SYNC_DLE, 8'h04, 8'h04, "empty set");
        get(SEL_SYNC_DLE, 8'h04, 8'h04, "empty kept by read");
        put(SEL_DATA, 8'h11);
        @(posedge clock);
        tx_empty <= 1'b0;
        get(SEL_SYNC_DLE, 8'h00, 8'h04, "empty cleared by load");
        pop;
        modem(1'b1, 1'b1);
        get(SEL_SYNC_DLE, 8'h04, 8'h04, "carrier change");
        get(SEL_SYNC_DLE, 8'h00, 8'h04, "change cleared by read");
        modem(1'b1, 1'b0);
        check(16'(pins_f[2]), 16'h0000, "full dset change");
        get(SEL_SYNC_DLE, 8'h00, 8'h84, "dset ignored");
        put(SEL_CMD, 8'h00);
        modem(1'b0, 1'b0);
        get(SEL_SYNC_DLE, 8'h00, 8'h04, "change masked");
        put(SEL_CMD, 8'h07);
        push(8'h3c, 1'b1, "push first");
        push(8'h3d, 1'b1, "push second");
        push(8'h3e, 1'b0, "push refused full");
        check(16'(irq_pin), 16'h0000, "irq on rx");
        check(16'(pins_f), 16'h0004, "full pins on rx");
        get(SEL_SYNC_DLE, 8'h02, 8'h02, "rx ready");
        get(SEL_DATA, 8'h3c, 8'hff, "rx first");
        get(SEL_DATA, 8'h3d, 8'hff, "rx second");
        get(SEL_SYNC_DLE, 8'h00, 8'h02, "rx drained");
        push(8'h3f, 1'b1, "push again");
        put(SEL_CMD, 8'h01);
        get(SEL_SYNC_DLE, 8'h00, 8'h02, "rx off clears");
        push(8'h40, 1'b0, "push refused disabled");
        @(posedge clock);
        master_reset <= 1'b1;
        @(posedge clock);
        master_reset <= 1'b0;
        #1;
        check({cmd_q, mode2_q}, 16'h0000, "master reset");
        print_verdict;
    end

    initial
    begin
        #900000;
        miscompares++;
        $display("wrong value at %0t: watchdog expired", $time);
        print_verdict;
    end
endmodule : serial_ctrl_host_port_test
